// file: core/cache_dir_pkg.sv
package cache_dir_pkg;
// Function
// - Direct-mapped mode addresses one 8K by 32-bit data bank.
// - Two-way mode addresses two banks, one per way, each 4K by 32 bits.
// - Directory holds 1024 tags, 8192 line valid bits, 512 replacement bits.
// - Direct-mapped keeps at most one entry per line offset.
// - Two-way keeps two entries per offset; a match in either way hits.
// - Address-status strobe starts a cycle; controller captures the address then.
// - On a read hit assert the output enable of the hitting way.
// - After hit data is driven, assert cycle done to end the cycle.
// - On a miss clear target valid bits, then fetch memory with bus controls.
// - Processor write is captured and completed with zero wait states; the code stalls it while the write buffer is still full.
// - Buffered write goes to memory once the system bus is ours.
// - Directory lookup alternates between processor and snoop addresses.
// - In master mode answer a hold request with hold grant.
// - A snooped write to a resident location clears its valid bit.
// - Snoop strobe pulses once per system address; controller latches it.
// - Flush input invalidates the entire cache.

    localparam int unsigned NUM_TAGS  = 1024;
    localparam int unsigned NUM_REPL  = 512;
    localparam int unsigned TAG_W     = 18;
    localparam int unsigned LINE_W    = 8;
    localparam int unsigned CADDR_W   = 13;

    typedef enum logic [2:0] {
        C_IDLE = 3'b000,
        C_LOOK = 3'b001,
        C_HIT  = 3'b010,
        C_FILL = 3'b011,
        C_END  = 3'b100
    } cpu_state_e;

    typedef enum logic [1:0] {
        B_IDLE  = 2'b00,
        B_WRITE = 2'b01,
        B_READ  = 2'b10
    } bus_state_e;

    typedef struct packed {
        cpu_state_e         cst;
        bus_state_e         bst;
        logic               phase;
        logic [31:2]        req_addr;
        logic               req_wr;
        logic [3:0]         req_be_n;
        logic [CADDR_W-1:0] cache_addr;
        logic               victim;
        logic               wb_valid;
        logic [31:2]        wb_addr;
        logic [31:0]        wb_data;
        logic [3:0]         wb_be_n;
        logic               snp_pend;
        logic [31:2]        snp_addr;
        logic               grant;
        logic [1:0]         oe_n;
        logic [1:0]         we_n;
        logic               done_n;
        logic               alc;
        logic               aden_n;
        logic               dls;
        logic               dden_n;
        logic               dir;
        logic               sys_wr;
        logic [31:2]        sys_addr;
        logic [31:0]        sys_data;
        logic [3:0]         sys_be_n;
    } state_s;

    typedef struct packed {
        logic              tag_we;
        logic [9:0]        tag_idx;
        logic [TAG_W-1:0]  tag_val;
        logic              vld_clr8;
        logic              vld_clr1;
        logic              vld_set;
        logic [9:0]        vld_idx;
        logic [2:0]        vld_bit;
        logic              repl_we;
        logic [8:0]        repl_idx;
        logic              repl_val;
        logic              snp_clr;
        logic [9:0]        snp_idx;
        logic [2:0]        snp_bit;
    } dir_upd_s;

    localparam state_s STATE_RST = '{
        cst: C_IDLE, bst: B_IDLE, oe_n: 2'h3, we_n: 2'h3, done_n: 1'b1,
        aden_n: 1'b1, dden_n: 1'b1, sys_be_n: 4'hf, default: '0};
endpackage

// file: core/cache_directory_controller.sv
`timescale 1ns/1ps
module cache_directory_controller (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    // Configuration straps
    input  wire logic        two_way_i,
    input  wire logic        master_mode_i,
    // Processor local bus
    input  wire logic        cpu_ads_n_i,
    input  wire logic [31:2] cpu_addr_i,
    input  wire logic        cpu_wr_i,
    input  wire logic [3:0]  cpu_be_n_i,
    input  wire logic [31:0] cpu_data_i,
    output logic             cycle_done_out_n_o,
    // Cache data RAM
    output logic [12:0]      cache_addr_o,
    output logic [1:0]       cache_ram_output_enable_n_o,
    output logic [1:0]       cache_we_n_o,
    output logic [3:0]       cache_be_n_o,
    // System bus
    input  wire logic        sys_ready_n_i,
    output logic             sys_addr_latch_clock_o,
    output logic             sys_addr_drive_enable_n_o,
    output logic             sys_data_latch_strobe_o,
    output logic             sys_data_drive_enable_n_o,
    output logic             sys_data_direction_o,
    output logic             sys_wr_o,
    output logic [31:2]      sys_addr_o,
    output logic [31:0]      sys_data_o,
    output logic [3:0]       sys_be_n_o,
    // Bus hold
    input  wire logic        sys_bus_hold_request_i,
    output logic             sys_bus_hold_grant_o,
    // Snoop and flush
    input  wire logic        snoop_enable_i,
    input  wire logic        snoop_strobe_i,
    input  wire logic        snoop_write_i,
    input  wire logic [31:2] snoop_addr_i,
    input  wire logic        flush_i
);
    cache_dir_pkg::state_s   s;
    cache_dir_pkg::state_s   s_nxt;
    cache_dir_pkg::dir_upd_s u;

    logic [cache_dir_pkg::TAG_W-1:0]  tag_q  [cache_dir_pkg::NUM_TAGS];
    logic [cache_dir_pkg::LINE_W-1:0] vld_q  [cache_dir_pkg::NUM_TAGS];
    logic [cache_dir_pkg::NUM_REPL-1:0] repl_q;
    logic [1:0] cpu_hit;
    logic [1:0] snp_hit;

    // Direct-mapped mode never looks at way 1
    // Way 1 only exists in two-way mode; the index bit then comes from the way
    function automatic logic [9:0] entry_of(logic [31:2] a, logic w, logic tw);
        return tw ? {w, a[13:5]} : a[14:5];
    endfunction

    function automatic logic [1:0] hit_of(logic [31:2] a, logic tw);
        logic [9:0] e;
        logic [1:0] h;
        h = 2'b00;
        for (int w = 0; w < 2; w++) begin
            e = entry_of(a, w[0], tw);
            h[w] = (w == 0 || tw) && vld_q[e][a[4:2]] && (tag_q[e] == a[31:14]);
        end
        return h;
    endfunction

    // Processor and snoop lookups share one directory port by phase
    assign cpu_hit = hit_of(s.req_addr, two_way_i);
    assign snp_hit = hit_of(s.snp_addr, two_way_i);

    always_comb begin
        logic       vw;
        logic [9:0] e;
        vw = 1'b0;
        e = '0;
        s_nxt = s;
        u = '0;
        s_nxt.phase = ~s.phase;
        s_nxt.alc = 1'b0;
        s_nxt.dls = 1'b0;
        case (s.cst)
            cache_dir_pkg::C_IDLE: begin
                if (!cpu_ads_n_i) begin
                    s_nxt.req_addr = cpu_addr_i;
                    s_nxt.req_wr = cpu_wr_i;
                    s_nxt.req_be_n = cpu_be_n_i;
                    s_nxt.cache_addr = two_way_i ? {1'b0, cpu_addr_i[13:2]}
                                                 : cpu_addr_i[14:2];
                    s_nxt.cst = cache_dir_pkg::C_LOOK;
                end
            end
            cache_dir_pkg::C_LOOK: begin
                // Processor owns the lookup port on even phase only
                if (!s.phase) begin
                    u.repl_idx = s.req_addr[13:5];
                    u.repl_val = ~cpu_hit[1];
                    if (s.req_wr) begin
                        // Full buffer stalls the write until the drain finishes
                        if (!s.wb_valid) begin
                            s_nxt.wb_valid = 1'b1;
                            s_nxt.wb_addr = s.req_addr;
                            s_nxt.wb_data = cpu_data_i;
                            s_nxt.wb_be_n = s.req_be_n;
                            s_nxt.dls = 1'b1;
                            s_nxt.we_n = ~cpu_hit;
                            s_nxt.done_n = 1'b0;
                            s_nxt.cst = cache_dir_pkg::C_END;
                            u.repl_we = two_way_i && (|cpu_hit);
                        end
                    end else if (|cpu_hit) begin
                        s_nxt.oe_n = ~cpu_hit;
                        s_nxt.cst = cache_dir_pkg::C_HIT;
                        u.repl_we = two_way_i;
                    end else begin
                        vw = two_way_i && repl_q[s.req_addr[13:5]];
                        e = entry_of(s.req_addr, vw, two_way_i);
                        s_nxt.victim = vw;
                        u.tag_we = 1'b1;
                        u.tag_idx = e;
                        u.tag_val = s.req_addr[31:14];
                        u.vld_idx = e;
                        u.vld_bit = s.req_addr[4:2];
                        u.vld_clr8 = tag_q[e] != s.req_addr[31:14];
                        u.vld_clr1 = 1'b1;
                        s_nxt.cst = cache_dir_pkg::C_FILL;
                    end
                end
            end
            cache_dir_pkg::C_HIT: begin
                s_nxt.done_n = 1'b0;
                s_nxt.cst = cache_dir_pkg::C_END;
            end
            cache_dir_pkg::C_FILL: begin
                // Reads wait behind the posted write to keep memory order
                if (s.bst == cache_dir_pkg::B_IDLE && !s.wb_valid && !s.grant) begin
                    s_nxt.bst = cache_dir_pkg::B_READ;
                    s_nxt.alc = 1'b1;
                    s_nxt.aden_n = 1'b0;
                    s_nxt.dden_n = 1'b0;
                    s_nxt.dir = 1'b0;
                    s_nxt.sys_wr = 1'b0;
                    s_nxt.sys_addr = s.req_addr;
                    s_nxt.sys_be_n = s.req_be_n;
                end else if (s.bst == cache_dir_pkg::B_READ && !sys_ready_n_i) begin
                    s_nxt.bst = cache_dir_pkg::B_IDLE;
                    s_nxt.aden_n = 1'b1;
                    s_nxt.dden_n = 1'b1;
                    s_nxt.we_n[s.victim] = 1'b0;
                    s_nxt.done_n = 1'b0;
                    s_nxt.cst = cache_dir_pkg::C_END;
                    u.vld_set = 1'b1;
                    u.vld_idx = entry_of(s.req_addr, s.victim, two_way_i);
                    u.vld_bit = s.req_addr[4:2];
                    u.repl_we = two_way_i;
                    u.repl_idx = s.req_addr[13:5];
                    u.repl_val = ~s.victim;
                end
            end
            default: begin
                s_nxt.oe_n = 2'h3;
                s_nxt.we_n = 2'h3;
                s_nxt.done_n = 1'b1;
                s_nxt.cst = cache_dir_pkg::C_IDLE;
            end
        endcase
        if (s.bst == cache_dir_pkg::B_WRITE && !sys_ready_n_i) begin
            s_nxt.bst = cache_dir_pkg::B_IDLE;
            s_nxt.wb_valid = 1'b0;
            s_nxt.aden_n = 1'b1;
            s_nxt.dden_n = 1'b1;
        end else if (s.bst == cache_dir_pkg::B_IDLE && s_nxt.bst == cache_dir_pkg::B_IDLE
                     && s.wb_valid && !s.grant) begin
            s_nxt.bst = cache_dir_pkg::B_WRITE;
            s_nxt.alc = 1'b1;
            s_nxt.aden_n = 1'b0;
            s_nxt.dden_n = 1'b0;
            s_nxt.dir = 1'b1;
            s_nxt.sys_wr = 1'b1;
            s_nxt.sys_addr = s.wb_addr;
            s_nxt.sys_data = s.wb_data;
            s_nxt.sys_be_n = s.wb_be_n;
        end
        // Grant only between our own transfers, held while requested
        s_nxt.grant = master_mode_i && sys_bus_hold_request_i && (s.grant ||
                      (s.bst == cache_dir_pkg::B_IDLE && s_nxt.bst == cache_dir_pkg::B_IDLE));
        if (s.phase && s.snp_pend) begin
            s_nxt.snp_pend = 1'b0;
            u.snp_clr = |snp_hit;
            u.snp_idx = entry_of(s.snp_addr, snp_hit[1], two_way_i);
            u.snp_bit = s.snp_addr[4:2];
        end
        // New strobe beats the clear of the previous one
        if (snoop_enable_i && snoop_strobe_i && snoop_write_i) begin
            s_nxt.snp_pend = 1'b1;
            s_nxt.snp_addr = snoop_addr_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= cache_dir_pkg::STATE_RST;
        end else begin
            s <= s_nxt;
        end
    end

    // Tags need no reset; valid bits guard them
    always_ff @(posedge ref_clk_i) begin
        if (u.tag_we) begin
            tag_q[u.tag_idx] <= u.tag_val;
        end
    end

    // Flush beats every same-cycle valid and replacement bit update, but not a tag write
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < cache_dir_pkg::NUM_TAGS; i++) begin
                vld_q[i] <= '0;
            end
            repl_q <= '0;
        end else if (flush_i) begin
            for (int i = 0; i < cache_dir_pkg::NUM_TAGS; i++) begin
                vld_q[i] <= '0;
            end
        end else begin
            if (u.vld_clr8) begin
                vld_q[u.vld_idx] <= '0;
            end else if (u.vld_clr1) begin
                vld_q[u.vld_idx][u.vld_bit] <= 1'b0;
            end else if (u.vld_set) begin
                vld_q[u.vld_idx][u.vld_bit] <= 1'b1;
            end
            if (u.repl_we) begin
                repl_q[u.repl_idx] <= u.repl_val;
            end
            // Snoop clear last so coherency wins over a same-cycle fill
            if (u.snp_clr) begin
                vld_q[u.snp_idx][u.snp_bit] <= 1'b0;
            end
        end
    end

    assign cycle_done_out_n_o          = s.done_n;
    assign cache_addr_o                = s.cache_addr;
    assign cache_ram_output_enable_n_o = s.oe_n;
    assign cache_we_n_o                = s.we_n;
    assign cache_be_n_o                = s.req_be_n;
    assign sys_addr_latch_clock_o      = s.alc;
    assign sys_addr_drive_enable_n_o   = s.aden_n;
    assign sys_data_latch_strobe_o     = s.dls;
    assign sys_data_drive_enable_n_o   = s.dden_n;
    assign sys_data_direction_o        = s.dir;
    assign sys_wr_o                    = s.sys_wr;
    assign sys_addr_o                  = s.sys_addr;
    assign sys_data_o                  = s.sys_data;
    assign sys_be_n_o                  = s.sys_be_n;
    assign sys_bus_hold_grant_o        = s.grant;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    ads_capture_a: assert property ((s.cst == cache_dir_pkg::C_IDLE && !cpu_ads_n_i)
        |=> s.req_addr == $past(cpu_addr_i) && s.cst == cache_dir_pkg::C_LOOK)
        else $error("address not captured on strobe");
    hit_enable_a: assert property ((s.cst == cache_dir_pkg::C_LOOK && !s.phase && !s.req_wr
        && |cpu_hit) |=> s.oe_n == ~$past(cpu_hit))
        else $error("wrong output enable on hit");
    hit_done_a: assert property ((s.cst == cache_dir_pkg::C_HIT)
        |=> !cycle_done_out_n_o && s.oe_n != 2'h3 ##1 cycle_done_out_n_o)
        else $error("cycle done not after hit data");
    miss_fill_a: assert property ((s.cst == cache_dir_pkg::C_LOOK && !s.phase && !s.req_wr
        && cpu_hit == 2'b00) |=> s.cst == cache_dir_pkg::C_FILL && cpu_hit == 2'b00)
        else $error("miss did not invalidate and fill");
    write_post_a: assert property ((s.cst == cache_dir_pkg::C_LOOK && !s.phase && s.req_wr
        && !s.wb_valid) |=> !s.done_n && s.wb_valid && s.dls)
        else $error("write not posted with zero wait");
    drain_start_a: assert property ($rose(s.bst == cache_dir_pkg::B_WRITE)
        |-> !$past(s.grant) && s.sys_addr == $past(s.wb_addr) && s.alc)
        else $error("posted write started wrongly");
    hold_excl_a: assert property (sys_bus_hold_grant_o
        |-> s.bst == cache_dir_pkg::B_IDLE && s.aden_n)
        else $error("grant during own transfer");
    snoop_clear_a: assert property ((s.phase && s.snp_pend && |snp_hit && !flush_i)
        |=> hit_of($past(s.snp_addr), two_way_i) == 2'b00)
        else $error("snooped write left line valid");
    flush_all_a: assert property (flush_i |=> cpu_hit == 2'b00 && snp_hit == 2'b00)
        else $error("flush left valid lines");
    fill_way_a: assert property ((s.cst == cache_dir_pkg::C_LOOK && !s.phase
        && !s.req_wr && two_way_i && cpu_hit == 2'b00)
        |=> s.victim == $past(repl_q[s.req_addr[13:5]]))
        else $error("fill way not from replacement bit");
    snoop_latch_a: assert property ((snoop_enable_i && snoop_strobe_i && snoop_write_i)
        |=> s.snp_pend && s.snp_addr == $past(snoop_addr_i))
        else $error("snoop address not latched");
    grant_mode_a: assert property (!master_mode_i |=> !sys_bus_hold_grant_o)
        else $error("grant outside master mode");

    hit_read_c: cover property (s.cst == cache_dir_pkg::C_HIT);
    miss_done_c: cover property (s.cst == cache_dir_pkg::C_FILL ##[1:40] !s.done_n);
    write_drain_c: cover property (s.bst == cache_dir_pkg::B_WRITE && !sys_ready_n_i);
    snoop_hit_c: cover property (s.phase && s.snp_pend && |snp_hit);
    hold_grant_c: cover property ($rose(sys_bus_hold_grant_o));
endmodule // cache_directory_controller

// file: dv/cache_directory_controller_test.sv
`timescale 1ns/1ps
module cache_directory_controller_test;
    logic        ref_clk_i = 1'b0, arst_n_i = 1'b0, two_way_i = 1'b0, master_mode_i = 1'b1;
    logic        cpu_ads_n_i = 1'b1, cpu_wr_i = 1'b0, sys_ready_n_i;
    logic [31:2] cpu_addr_i = '0, snoop_addr_i = '0, sys_addr_o;
    logic [3:0]  cpu_be_n_i = 4'h0, cache_be_n_o, sys_be_n_o, lat = 4'h2;
    logic [31:0] cpu_data_i = '0, sys_data_o;
    logic        cycle_done_out_n_o, sys_addr_latch_clock_o, sys_addr_drive_enable_n_o;
    logic        sys_data_latch_strobe_o, sys_data_drive_enable_n_o, sys_data_direction_o;
    logic        sys_wr_o, sys_bus_hold_request_i = 1'b0, sys_bus_hold_grant_o, flush_i = 1'b0;
    logic        snoop_enable_i = 1'b0, snoop_strobe_i = 1'b0, snoop_write_i = 1'b0;
    logic [12:0] cache_addr_o;
    logic [1:0]  cache_ram_output_enable_n_o, cache_we_n_o;
    int          fails = 0, total_checks = 0;
    localparam logic [31:2] ADDR_A = 30'h0000_0104, ADDR_B = 30'h0000_2104;
    localparam logic [31:2] ADDR_C = 30'h0000_1104, ADDR_W = 30'h0000_3208;

    always #20 ref_clk_i = ~ref_clk_i;

    cache_directory_controller u_cache_directory_controller (
        .ref_clk_i                   (ref_clk_i),
        .arst_n_i                    (arst_n_i),
        .two_way_i                   (two_way_i),
        .master_mode_i               (master_mode_i),
        .cpu_ads_n_i                 (cpu_ads_n_i),
        .cpu_addr_i                  (cpu_addr_i),
        .cpu_wr_i                    (cpu_wr_i),
        .cpu_be_n_i                  (cpu_be_n_i),
        .cpu_data_i                  (cpu_data_i),
        .cycle_done_out_n_o          (cycle_done_out_n_o),
        .cache_addr_o                (cache_addr_o),
        .cache_ram_output_enable_n_o (cache_ram_output_enable_n_o),
        .cache_we_n_o                (cache_we_n_o),
        .cache_be_n_o                (cache_be_n_o),
        .sys_ready_n_i               (sys_ready_n_i),
        .sys_addr_latch_clock_o      (sys_addr_latch_clock_o),
        .sys_addr_drive_enable_n_o   (sys_addr_drive_enable_n_o),
        .sys_data_latch_strobe_o     (sys_data_latch_strobe_o),
        .sys_data_drive_enable_n_o   (sys_data_drive_enable_n_o),
        .sys_data_direction_o        (sys_data_direction_o),
        .sys_wr_o                    (sys_wr_o),
        .sys_addr_o                  (sys_addr_o),
        .sys_data_o                  (sys_data_o),
        .sys_be_n_o                  (sys_be_n_o),
        .sys_bus_hold_request_i      (sys_bus_hold_request_i),
        .sys_bus_hold_grant_o        (sys_bus_hold_grant_o),
        .snoop_enable_i              (snoop_enable_i),
        .snoop_strobe_i              (snoop_strobe_i),
        .snoop_write_i               (snoop_write_i),
        .snoop_addr_i                (snoop_addr_i),
        .flush_i                     (flush_i)
    );
    sys_mem_model u_sys_mem_model (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .lat_i(lat),
        .aden_n_i(sys_addr_drive_enable_n_o), .ready_n_o(sys_ready_n_i));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic timed_out();
        fails++;
        $display("Error at %0t: wait bound used up", $time);
        tally_and_finish();
    endtask

    task automatic do_reset(input logic tw);
        arst_n_i = 1'b0;
        two_way_i = tw;
        repeat (2) @(posedge ref_clk_i);
        #1 arst_n_i = 1'b1;
        check({cycle_done_out_n_o, cache_ram_output_enable_n_o, sys_bus_hold_grant_o,
               sys_addr_drive_enable_n_o, sys_data_drive_enable_n_o}, 6'h3b);
    endtask

    // One processor cycle; miss is judged by a system transfer starting in it
    // Expected enables: output enable on a read hit, write enable otherwise
    task automatic cpu(input logic [31:2] a, input logic w, input logic miss,
                       input logic [1:0] oe);
        int   n;
        logic seen;
        n = 0;
        seen = 1'b0;
        @(posedge ref_clk_i);
        #1 cpu_ads_n_i = 1'b0;
        cpu_addr_i = a;
        cpu_wr_i = w;
        cpu_data_i = {a, 2'b00} ^ 32'h5a5a_5a5a;
        @(posedge ref_clk_i);
        #1 cpu_ads_n_i = 1'b1;
        while (cycle_done_out_n_o !== 1'b0) begin
            @(negedge ref_clk_i);
            if (sys_addr_latch_clock_o === 1'b1) begin
                seen = 1'b1;
                check({sys_data_direction_o, sys_data_drive_enable_n_o, sys_wr_o}, 3'b000);
            end
            n++;
            if (n > 60) timed_out();
        end
        check(seen, miss);
        check(cache_be_n_o, cpu_be_n_i);
        if (w) begin
            check({sys_data_latch_strobe_o, cache_we_n_o}, {1'b1, oe});
            check(n <= 3, 1'b1);
        end else if (miss) begin
            check(cache_we_n_o, oe);
        end else begin
            check(cache_ram_output_enable_n_o, oe);
            check(n <= 4, 1'b1);
            check(cache_addr_o, two_way_i ? {1'b0, a[13:2]} : a[14:2]);
        end
    endtask

    task automatic t_direct();
        cpu(ADDR_A, 1'b0, 1'b1, 2'b10);
        cpu(ADDR_A, 1'b0, 1'b0, 2'b10);
        lat = 4'h0;
        cpu(ADDR_B, 1'b0, 1'b1, 2'b10);
        cpu(ADDR_A, 1'b0, 1'b1, 2'b10);
        lat = 4'h5;
        $display("direct mapped test done");
    endtask

    task automatic t_write();
        int n;
        n = 0;
        @(posedge ref_clk_i);
        #1 cpu_be_n_i = 4'h3;
        cpu(ADDR_W, 1'b1, 1'b0, 2'b11);
        while (sys_addr_latch_clock_o !== 1'b1) begin
            @(negedge ref_clk_i);
            if (++n > 40) timed_out();
        end
        check({sys_wr_o, sys_data_direction_o, sys_be_n_o}, 6'h33);
        check(sys_addr_o, ADDR_W);
        check(sys_data_o, {ADDR_W, 2'b00} ^ 32'h5a5a_5a5a);
        while (sys_addr_drive_enable_n_o !== 1'b1) begin
            @(negedge ref_clk_i);
            if (++n > 80) timed_out();
        end
        $display("posted write test done");
    endtask

    task automatic t_hold();
        @(posedge ref_clk_i);
        #1 sys_bus_hold_request_i = 1'b1;
        @(posedge ref_clk_i);
        #1 check(sys_bus_hold_grant_o, 1'b1);
        sys_bus_hold_request_i = 1'b0;
        @(posedge ref_clk_i);
        #1 check(sys_bus_hold_grant_o, 1'b0);
        master_mode_i = 1'b0;
        sys_bus_hold_request_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1 check(sys_bus_hold_grant_o, 1'b0);
        sys_bus_hold_request_i = 1'b0;
        master_mode_i = 1'b1;
        $display("hold test done");
    endtask

    task automatic t_two_way();
        cpu(ADDR_A, 1'b0, 1'b1, 2'b10);
        cpu(ADDR_C, 1'b0, 1'b1, 2'b01);
        cpu(ADDR_A, 1'b0, 1'b0, 2'b10);
        cpu(ADDR_C, 1'b0, 1'b0, 2'b01);
        $display("two way test done");
    endtask

    task automatic t_snoop();
        @(posedge ref_clk_i);
        #1 snoop_enable_i = 1'b1;
        @(posedge ref_clk_i);
        #1 {snoop_strobe_i, snoop_write_i, snoop_addr_i} = {2'b11, ADDR_A};
        @(posedge ref_clk_i);
        #1 {snoop_strobe_i, snoop_write_i} = 2'b00;
        @(posedge ref_clk_i);
        #1 snoop_enable_i = 1'b0;
        cpu(ADDR_A, 1'b0, 1'b1, 2'b10);
        $display("snoop test done");
    endtask

    task automatic t_flush();
        cpu(ADDR_C, 1'b0, 1'b0, 2'b01);
        @(posedge ref_clk_i);
        #1 flush_i = 1'b1;
        @(posedge ref_clk_i);
        #1 flush_i = 1'b0;
        cpu(ADDR_C, 1'b0, 1'b1, 2'b10);
        $display("flush test done");
    endtask

    initial begin
        do_reset(1'b0);
        t_direct();
        t_write();
        t_hold();
        do_reset(1'b1);
        t_two_way();
        t_snoop();
        t_flush();
        tally_and_finish();
    end
endmodule // cache_directory_controller_test

// file: dv/sys_mem_model.sv
`timescale 1ns/1ps
module sys_mem_model (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       arst_n_i,
    // Latency setting and bus watch
    input  wire logic [3:0] lat_i,
    input  wire logic       aden_n_i,
    output logic            ready_n_o
);
    logic [3:0] cnt_r;
    logic       ans_r;

    // One answer per transfer; waits for the enable to drop before re-arming
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r     <= 4'h0;
            ans_r     <= 1'b0;
            ready_n_o <= 1'b1;
        end else begin
            ready_n_o <= 1'b1;
            if (aden_n_i) begin
                cnt_r <= 4'h0;
                ans_r <= 1'b0;
            end else if (!ans_r) begin
                if (cnt_r == lat_i) begin
                    ans_r     <= 1'b1;
                    ready_n_o <= 1'b0;
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end
endmodule // sys_mem_model
